// ==== design/dfosc_top.v ====
// output formatter, data strobe and start control of the decimating filter
`timescale 1ns/10ps
`include "dfosc_defs.vh"
module dfosc_top #(
  parameter ACC_W    = `DFOSC_ACC_W,
  parameter OUT_W    = `DFOSC_OUT_W,
  parameter SAMPLE_W = `DFOSC_SAMPLE_W
) (
  // clock and reset
  input  wire                i_core_clk,
  input  wire                i_resetn,
  // clock enables for the sample and filter rates
  input  wire                i_sample_clock_en,
  input  wire                i_filter_clock_en,
  // start pins
  input  wire                i_async_start_n,
  input  wire                i_sync_start_n,
  output wire                o_cascade_start_out_n,
  // configuration
  input  wire                i_filter_stage_bypass_bit,
  input  wire                i_upper_byte_select_pin,
  // sample input side
  input  wire [SAMPLE_W-1:0] i_sample_data,
  input  wire                i_sample_valid,
  output wire [SAMPLE_W-1:0] o_sample_data,
  output wire                o_sample_valid,
  // filter result side
  input  wire [ACC_W-1:0]    i_result,
  input  wire                i_result_valid,
  output wire [OUT_W-1:0]    o_data_out,
  output wire                o_data_ready,
  output wire                o_running
);

  // ===========================
  // start detection
  // both start pins need a high time before their falling edge counts; the
  // async pin passes a two-flop synchroniser first, which adds two clocks
  wire async_start;
  wire sync_start;

  dfosc_start_sync u_start (
    .i_core_clk      (i_core_clk),
    .i_resetn        (i_resetn),
    .i_sample_en     (i_sample_clock_en),
    .i_async_start_n (i_async_start_n),
    .i_sync_start_n  (i_sync_start_n),
    .o_async_start   (async_start),
    .o_sync_start    (sync_start)
  );

  // ===========================
  // start control state machine
  // an async start drives the cascade output low first and enters operation
  // only at the next sample edge; that is the edge on which a chained device,
  // whose sync start pin the cascade output drives, sees the low level and
  // starts too, so both devices begin with the same sample
  localparam [1:0] ST_IDLE = 2'h0; // reset state, starts looked for
  localparam [1:0] ST_CASC = 2'h1; // cascade start low, next sample edge awaited
  localparam [1:0] ST_RUN  = 2'h2; // operational mode, left only by reset

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg        run_ff;
  reg        nxt_run;
  reg        cascade_ff;
  reg        nxt_cascade;

  // next state; starts seen while running are ignored, a new start needs reset
  always @* begin
    nxt_state   = state_ff;
    nxt_run     = run_ff;
    nxt_cascade = cascade_ff;
    case (state_ff)
      ST_IDLE: begin
        if (sync_start) begin
          nxt_state = ST_RUN;
          nxt_run   = 1'b1;
        end else if (async_start) begin
          nxt_state   = ST_CASC;
          nxt_cascade = 1'b0;
        end
      end
      ST_CASC: begin
        if (i_sample_clock_en) begin
          nxt_state   = ST_RUN;
          nxt_run     = 1'b1;
          nxt_cascade = 1'b1;
        end
      end
      ST_RUN: begin
        nxt_run     = 1'b1;
        nxt_cascade = 1'b1;
      end
      default: begin
        nxt_state   = ST_IDLE;
        nxt_run     = 1'b0;
        nxt_cascade = 1'b1;
      end
    endcase
  end

  // state registers; reset holds the internal start inactive
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff   <= ST_IDLE;
      run_ff     <= `DFOSC_RUN_RST;
      cascade_ff <= 1'b1;
    end else begin
      state_ff   <= nxt_state;
      run_ff     <= nxt_run;
      cascade_ff <= nxt_cascade;
    end
  end

  // both are flip-flop outputs, so no glitch reaches a chained device
  assign o_cascade_start_out_n = cascade_ff;
  assign o_running             = run_ff;

  // ===========================
  // sample gate: the full sixteen-bit word is passed on, and nothing is
  // accepted before a start; a word offered while stopped is simply dropped
  wire                smp_take = run_ff & i_sample_valid & i_sample_clock_en;
  reg  [SAMPLE_W-1:0] smp_ff;
  reg                 smp_vld_ff;

  // one-cycle valid pulse, word held until the next accepted sample
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      smp_ff     <= {SAMPLE_W{1'b0}};
      smp_vld_ff <= 1'b0;
    end else begin
      smp_vld_ff <= smp_take;
      if (smp_take)
        smp_ff <= i_sample_data;
    end
  end
  assign o_sample_data  = smp_ff;
  assign o_sample_valid = smp_vld_ff;

  // ===========================
  // output formatter: two multiplexers pick 24 of the 40 register bits;
  // register bit 39 weighs -2^8, so bit 31 is the 2^0 position
  // upper byte multiplexer, steered by bypass and upper select
  function [7:0] fmt_hi;
    input [ACC_W-1:0] acc;
    input             byp;
    input             selh;
    begin
      if (!byp && selh)
        fmt_hi = acc[`DFOSC_HI_UPPER_MSB:`DFOSC_HI_UPPER_LSB]; // integer bits -2^8 to 2^1
      else
        fmt_hi = acc[`DFOSC_HI_FINE_MSB:`DFOSC_HI_FINE_LSB];   // fraction bits 2^-16 to 2^-23
    end
  endfunction

  // lower word multiplexer, steered by bypass alone
  function [15:0] fmt_lo;
    input [ACC_W-1:0] acc;
    input             byp;
    begin
      if (byp)
        fmt_lo = acc[`DFOSC_LO_BYP_MSB:`DFOSC_LO_BYP_LSB];   // fraction bits 2^-16 to 2^-31
      else
        fmt_lo = acc[`DFOSC_LO_NORM_MSB:`DFOSC_LO_NORM_LSB]; // bits 2^0 down to 2^-15
    end
  endfunction

  // both halves for one result word
  function [OUT_W-1:0] fmt_out;
    input [ACC_W-1:0] acc;
    input             byp;
    input             selh;
    begin
      fmt_out = {fmt_hi(acc, byp, selh), fmt_lo(acc, byp)};
    end
  endfunction

  // ===========================
  // output register and data ready strobe
  // a result is latched on one filter edge and the strobe raised on the
  // next, so the bus has been steady for a whole filter period when the
  // strobe rises; the strobe then stays high for one filter period, long
  // enough for capture logic on either rate to see its rising edge
  // results offered while stopped never reach the bus
  wire             res_take = i_result_valid & run_ff;
  reg  [OUT_W-1:0] out_ff;
  reg              pend_ff;
  reg              rdy_ff;

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_ff  <= {OUT_W{1'b0}};
      pend_ff <= 1'b0;
      rdy_ff  <= 1'b0;
    end else if (i_filter_clock_en) begin
      if (res_take)
        out_ff <= fmt_out(i_result, i_filter_stage_bypass_bit, i_upper_byte_select_pin);
      pend_ff <= res_take;
      rdy_ff  <= pend_ff;
    end
  end
  assign o_data_out   = out_ff;
  assign o_data_ready = rdy_ff;
endmodule

// ==== design/dfosc_defs.vh ====
// shared constants for the decimator output and start control block
`ifndef DFOSC_DEFS_VH
`define DFOSC_DEFS_VH
// output formatter widths and field positions
`define DFOSC_ACC_W      40
`define DFOSC_OUT_W      24
`define DFOSC_SAMPLE_W   16
// upper byte and lower word picks from the 40-bit output register (bit 39 weighs -2^8)
`define DFOSC_HI_UPPER_MSB  39
`define DFOSC_HI_UPPER_LSB  32
`define DFOSC_LO_NORM_MSB   31
`define DFOSC_LO_NORM_LSB   16
`define DFOSC_HI_FINE_MSB   15
`define DFOSC_HI_FINE_LSB   8
`define DFOSC_LO_BYP_MSB    15
`define DFOSC_LO_BYP_LSB    0
// start recognition: input high for at least this many sample cycles
`define DFOSC_START_HIGH_CYC 2'h2
`define DFOSC_RUN_RST        1'b0
`endif

// ==== design/dfosc_start_sync.v ====
// start input edge detector and asynchronous start synchroniser
`timescale 1ns/10ps
module dfosc_start_sync (
  // clock and reset
  input  wire       i_core_clk,
  input  wire       i_resetn,
  // sample clock enable and start pins
  input  wire       i_sample_en,
  input  wire       i_async_start_n,
  input  wire       i_sync_start_n,
  // recognised start pulses
  output wire       o_async_start,
  output wire       o_sync_start
);
`include "dfosc_defs.vh"

  // ===========================
  // asynchronous start synchroniser
  reg        async_meta_ff;
  reg        async_sync_ff;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      async_meta_ff <= 1'b1;
      async_sync_ff <= 1'b1;
    end else begin
      async_meta_ff <= i_async_start_n;
      async_sync_ff <= async_meta_ff;
    end
  end

  // ===========================
  // high-time counters, sampled on sample clock edges
  reg  [1:0] async_hi_ff;
  reg  [1:0] sync_hi_ff;
  wire       async_armed = (async_hi_ff >= `DFOSC_START_HIGH_CYC);
  wire       sync_armed  = (sync_hi_ff  >= `DFOSC_START_HIGH_CYC);

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      async_hi_ff <= 2'h0;
      sync_hi_ff  <= 2'h0;
    end else if (i_sample_en) begin
      if (async_sync_ff == 1'b0)
        async_hi_ff <= 2'h0;
      else if (!async_armed)
        async_hi_ff <= async_hi_ff + 2'h1;
      if (i_sync_start_n == 1'b0)
        sync_hi_ff <= 2'h0;
      else if (!sync_armed)
        sync_hi_ff <= sync_hi_ff + 2'h1;
    end
  end

  // falling edge after a long enough high time
  assign o_async_start = i_sample_en & async_armed & ~async_sync_ff;
  assign o_sync_start  = i_sample_en & sync_armed & ~i_sync_start_n;
endmodule

// ==== verification/dfosc_top_sva.sv ====
// concurrent checks on the decimator output and start control ports
`timescale 1ns/10ps
module dfosc_top_sva #(
  parameter OUT_W    = 24,
  parameter SAMPLE_W = 16
) (
  // clock, reset and enables
  input wire                i_core_clk, i_resetn, i_sample_clock_en, i_filter_clock_en,
  // observed inputs
  input wire [SAMPLE_W-1:0] i_sample_data,
  input wire                i_sample_valid, i_result_valid, i_sync_start_n,
  // observed outputs
  input wire [SAMPLE_W-1:0] o_sample_data,
  input wire [OUT_W-1:0]    o_data_out,
  input wire                o_sample_valid, o_data_ready, o_running, o_cascade_start_out_n
);
  // ==========
  // properties
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_rst; disable iff (1'b0) !i_resetn |-> !o_running && o_cascade_start_out_n; endproperty
  property p_idle; !o_running |=> !o_sample_valid && !o_data_ready; endproperty
  property p_pass; o_running && i_sample_clock_en && i_sample_valid
    |=> o_sample_valid && o_sample_data == $past(i_sample_data); endproperty
  property p_casc; $rose(o_running) && $past(i_sync_start_n) |-> !$past(o_cascade_start_out_n); endproperty
  property p_chain; !o_cascade_start_out_n && i_sample_clock_en |=> o_running; endproperty
  property p_cwid; $fell(o_cascade_start_out_n) |-> ##[1:4] o_cascade_start_out_n; endproperty
  property p_settle; $rose(o_data_ready) |-> $stable(o_data_out); endproperty
  property p_wide; $rose(o_data_ready) |=> o_data_ready; endproperty
  property p_rdy; o_running && i_filter_clock_en && i_result_valid |-> ##[1:6] $rose(o_data_ready); endproperty
  a_rst: assert property (p_rst) else $error("active during reset");
  a_idle: assert property (p_idle) else $error("output while stopped");
  a_pass: assert property (p_pass) else $error("sample not passed");
  a_casc: assert property (p_casc) else $error("no cascade start");
  a_chain: assert property (p_chain) else $error("not started with chained device");
  a_cwid: assert property (p_cwid) else $error("cascade start too long");
  a_settle: assert property (p_settle) else $error("bus moved at strobe");
  a_wide: assert property (p_wide) else $error("strobe too short");
  a_rdy: assert property (p_rdy) else $error("no ready strobe");
  c_run: cover property ($rose(o_running));
  c_rdy: cover property ($rose(o_data_ready));
  c_smp: cover property (o_sample_valid);
  c_casc: cover property ($fell(o_cascade_start_out_n));
endmodule
bind dfosc_top dfosc_top_sva #(.OUT_W(OUT_W), .SAMPLE_W(SAMPLE_W)) u_sva (
  .i_core_clk            (i_core_clk),
  .i_resetn              (i_resetn),
  .i_sample_clock_en     (i_sample_clock_en),
  .i_filter_clock_en     (i_filter_clock_en),
  .i_sample_data         (i_sample_data),
  .i_sample_valid        (i_sample_valid),
  .i_result_valid        (i_result_valid),
  .i_sync_start_n        (i_sync_start_n),
  .o_sample_data         (o_sample_data),
  .o_data_out            (o_data_out),
  .o_sample_valid        (o_sample_valid),
  .o_data_ready          (o_data_ready),
  .o_running             (o_running),
  .o_cascade_start_out_n (o_cascade_start_out_n)
);

// ==== verification/dfosc_capture.sv ====
// capture register model latching the output word on the ready rise
`timescale 1ns/10ps
module dfosc_capture (
  input  wire         i_core_clk,
  input  wire         i_ready,
  input  wire  [23:0] i_data,
  output logic [23:0] o_word,
  output int          o_count
);
  logic last_ff = 1'b0;
  int   count_ff = 0;
  assign o_count = count_ff;
  // latch on the rising edge of the strobe only
  always @(posedge i_core_clk) begin
    last_ff <= i_ready;
    if (i_ready && !last_ff) begin
      o_word  <= i_data;
      count_ff <= count_ff + 1;
    end
  end
endmodule

// ==== verification/decimator_output_start_control_test.sv ====
// self-checking bench for the decimator output and start control block
`timescale 1ns/10ps
module decimator_output_start_control_test;
  logic        i_core_clk = 0, i_resetn = 1, i_sample_clock_en = 0, i_filter_clock_en = 0;
  logic        i_async_start_n = 1, i_sync_start_n = 0, i_filter_stage_bypass_bit = 0;
  logic        i_upper_byte_select_pin = 0, i_sample_valid = 0, i_result_valid = 0;
  logic [15:0] i_sample_data = 16'h0000;
  logic [39:0] i_result = 40'h0000000000;
  wire  [15:0] o_sample_data;
  wire  [23:0] o_data_out, cap_word;
  wire         o_sample_valid, o_data_ready, o_running, o_cascade_start_out_n;
  int          failures = 0, n_compared = 0, cyc = 0, cap_n;
  logic [7:0]  rnd = 8'h4c;
  logic [23:0] exp_q[$];
  dfosc_top DUT (
    .i_core_clk                (i_core_clk),
    .i_resetn                  (i_resetn),
    .i_sample_clock_en         (i_sample_clock_en),
    .i_filter_clock_en         (i_filter_clock_en),
    .i_async_start_n           (i_async_start_n),
    .i_sync_start_n            (i_sync_start_n),
    .o_cascade_start_out_n     (o_cascade_start_out_n),
    .i_filter_stage_bypass_bit (i_filter_stage_bypass_bit),
    .i_upper_byte_select_pin   (i_upper_byte_select_pin),
    .i_sample_data             (i_sample_data),
    .i_sample_valid            (i_sample_valid),
    .o_sample_data             (o_sample_data),
    .o_sample_valid            (o_sample_valid),
    .i_result                  (i_result),
    .i_result_valid            (i_result_valid),
    .o_data_out                (o_data_out),
    .o_data_ready              (o_data_ready),
    .o_running                 (o_running)
  );
  dfosc_capture u_cap (.i_core_clk(i_core_clk), .i_ready(o_data_ready), .i_data(o_data_out),
                       .o_word(cap_word), .o_count(cap_n));
  initial forever #12.5 i_core_clk = ~i_core_clk;
  // ==========
  // model and tasks
  function automatic [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // expected word: bypass takes the fine bits, select picks the upper byte
  function automatic [23:0] fmt(input [39:0] r, input b, input s);
    fmt = b ? {r[15:8], r[15:0]} : {s ? r[39:32] : r[15:8], r[31:16]};
  endfunction
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one cycle: enables alternate, hang cut short by the cycle ceiling
  task automatic tick;
    @(posedge i_core_clk);
    #1;
    cyc++;
    i_sample_clock_en = cyc[0];
    i_filter_clock_en = cyc[0];
    if (cyc > 2000) begin
      failures++;
      stop_test;
    end
  endtask
  task automatic sample(input logic ev);
    tick;
    if (!i_sample_clock_en) tick;
    rnd = lfsr(rnd);
    i_sample_data = {rnd, ~rnd};
    i_sample_valid = 1;
    tick;
    i_sample_valid = 0;
    chk(o_sample_valid, ev);
    if (ev) chk(o_sample_data, i_sample_data);
  endtask
  task automatic result(input logic b, input logic s, input logic ev);
    int n;
    n = cap_n;
    i_filter_stage_bypass_bit = b;
    i_upper_byte_select_pin = s;
    tick;
    if (!i_filter_clock_en) tick;
    rnd = lfsr(rnd);
    i_result = {rnd, ~rnd, rnd ^ 8'h5a, ~rnd, rnd};
    if (ev) exp_q.push_back(fmt(i_result, b, s));
    i_result_valid = 1;
    tick;
    i_result_valid = 0;
    repeat (10) tick;
    chk(cap_n - n, ev);
    if (ev) chk(cap_word, exp_q.pop_front());
  endtask
  task automatic start(input logic use_async);
    logic casc_seen;
    casc_seen = 0;
    i_sync_start_n = 1;
    repeat (6) tick;
    i_async_start_n = !use_async;
    i_sync_start_n = use_async;
    for (int k = 0; k < 12 && o_running !== 1'b1; k++) begin
      tick;
      if (o_cascade_start_out_n === 1'b0 && o_running !== 1'b1) casc_seen = 1;
    end
    chk(casc_seen, use_async);
    chk(o_running, 1);
    i_async_start_n = 1;
    i_sync_start_n = 1;
  endtask
  initial begin
    #1 i_resetn = 0;
    repeat (2) @(posedge i_core_clk);
    #1 i_resetn = 1;
    sample(0);
    result(0, 1, 0);
    chk(o_running, 0);
    $display("test idle done");
    start(0);
    for (int i = 0; i < 8; i++) result(i[1], i[0], 1);
    repeat (4) sample(1);
    $display("test sync start done");
    i_resetn = 0;
    tick;
    chk(o_running, 0);
    i_resetn = 1;
    start(1);
    sample(1);
    $display("test async start done");
    stop_test;
  end
endmodule
